//--- verif/core_seq_model.sv
`timescale 1ns/1ps

module core_seq_model (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Request offered by the block.
  input  wire logic       intr_request_r,
  input  wire logic [3:0] intr_vector_r,
  // Bench controls: acknowledge on or off, and how long to wait.
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_delay,
  // Acknowledge toward the block, and a log of what was served.
  output logic            intr_ack,
  output logic [3:0]      served_vec,
  output int              served_cnt
);
  logic [3:0] wait_r;  // Cycles the current request has stood unanswered.

  // The acknowledge is raised only while a request is offered, after the
  // chosen wait, so both a prompt and a slow core can be played.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      intr_ack   <= 1'h0;
      wait_r     <= 4'h0;
      served_vec <= 4'h0;
      served_cnt <= 0;
    end else if (intr_ack) begin
      // The vector is logged at the edge where the block takes the ack.
      intr_ack   <= 1'h0;
      wait_r     <= 4'h0;
      served_vec <= intr_vector_r;
      served_cnt <= served_cnt + 1;
    end else if (intr_request_r && ack_en) begin
      intr_ack <= (wait_r == ack_delay);
      wait_r   <= wait_r + 4'h1;
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule : core_seq_model

//--- verif/test_interrupt_flag_control.sv
`timescale 1ns/1ps

module test_interrupt_flag_control;
  import intr_flag_pkg::*;

  logic              core_clk = 1'b0;  // 40 MHz system clock.
  logic              rst_n    = 1'b0;  // Held low from time zero.
  logic              reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 6'h00;
  logic [DATA_W-1:0] reg_wr_data = 4'h0, reg_rd_data_r;
  logic              int_pin = 1'b0;
  logic [5:0]        stb = 6'h00;  // Strobes: match, done, on, off, restart, stop.
  logic              intr_ack, intr_request_r, ack_en = 1'b0;
  logic [VEC_W-1:0]  intr_vector_r, served_vec;
  logic [3:0]        ack_delay = 4'h0;
  int                served_cnt, n_fail = 0, n_compared = 0, cyc = 0, prev, k;
  // Rows: address, data written, value read back afterwards.
  logic [13:0]       rows [7] = '{{6'h1F, 4'hF, 4'h3}, {6'h2F, 4'hF, 4'h7},
    {6'h3D, 4'hF, 4'h1}, {6'h3E, 4'hF, 4'h1}, {6'h3F, 4'hF, 4'h1},
    {6'h0F, 4'hF, 4'h0}, {6'h10, 4'hF, 4'h0}};
  logic [3:0]        vecs [3] = '{VEC_PIN, VEC_TIMER, VEC_SERIAL};

  always #12.5 core_clk = ~core_clk;

  interrupt_flag_control u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data_r(reg_rd_data_r), .int_pin(int_pin),
    .timer_match(stb[0]), .serial_done(stb[1]), .accept_on_instr(stb[2]),
    .accept_off_instr(stb[3]), .timer_restart_bit(stb[4]),
    .stop_instr(stb[5]), .intr_ack(intr_ack),
    .intr_request_r(intr_request_r), .intr_vector_r(intr_vector_r));

  core_seq_model u_core (
    .core_clk(core_clk), .rst_n(rst_n), .intr_request_r(intr_request_r),
    .intr_vector_r(intr_vector_r), .ack_en(ack_en), .ack_delay(ack_delay),
    .intr_ack(intr_ack), .served_vec(served_vec), .served_cnt(served_cnt));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // One comparison of four-state values.
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // All tasks start and end 2 ns after a rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick

  // One register write; stored state changes one cycle later. An idle
  // edge follows, so a second call never raises the strobe in the very
  // time step in which this one lowered it.
  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    reg_wr_en = 1'h1;
    reg_addr = a;
    reg_wr_data = d;
    tick(1);
    reg_wr_en = 1'h0;
    tick(1);
  endtask : wr

  // One register read; the data is registered at the sampling edge.
  // The data is taken at that edge, then one idle edge is let pass.
  task automatic rd(input logic [5:0] a, input logic [3:0] exp);
    reg_rd_en = 1'h1;
    reg_addr = a;
    tick(1);
    chk(reg_rd_data_r, exp);
    reg_rd_en = 1'h0;
    tick(1);
  endtask : rd

  // One-cycle strobe pulse on the chosen instruction or source lines.
  task automatic pulse(input logic [5:0] m);
    stb = m;
    tick(1);
    stb = 6'h00;
  endtask : pulse

  // Reset is held for four cycles, also when applied in mid-run.
  task automatic do_reset;
    rst_n = 1'b0;
    tick(4);
    rst_n = 1'b1;
  endtask : do_reset

  // A hang is cut short well past the few hundred cycles the tests need.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      $display("ERROR at %0t: run did not finish", $time);
      stop_test();
    end
  end

  initial begin
    do_reset();
    foreach (rows[i]) rd(rows[i][13:8], 4'h0);
    // Ordinary cases: write each place, read back what should remain.
    foreach (rows[i]) begin
      wr(rows[i][13:8], rows[i][7:4]);
      rd(rows[i][13:8], rows[i][3:0]);
    end
    wr(6'h3D, 4'h0);
    rd(6'h3D, 4'h0);
    // Every edge code, with a rise and then a fall on the pin.
    for (int s = 0; s < 4; s++) begin
      wr(6'h1F, 4'(s));
      wr(6'h3F, 4'h0);
      int_pin = 1'b1;
      tick(6);
      rd(6'h3F, {3'h0, s != 1});
      rd(6'h0F, 4'h1);
      wr(6'h3F, 4'h0);
      int_pin = 1'b0;
      tick(6);
      rd(6'h3F, {3'h0, s != 0});
      rd(6'h0F, 4'h0);
    end
    // Three sources at once are served in order, each re-enabled.
    wr(6'h2F, 4'h7);
    pulse(6'h03);
    wr(6'h3F, 4'h1);
    ack_en = 1'b1;
    for (int i = 0; i < 3; i++) begin
      ack_delay = 4'(i * 2);
      prev = served_cnt;
      pulse(6'h04);
      k = 0;
      while (served_cnt == prev && k < 30) begin
        tick(1);
        k++;
      end
      chk(served_vec, vecs[i]);
      tick(2);
      chk({3'h0, intr_request_r}, 4'h0);
    end
    rd(6'h3F, 4'h0);
    rd(6'h3E, 4'h0);
    rd(6'h3D, 4'h0);
    // Disable instruction and enable bit each hold a request back.
    ack_en = 1'b0;
    wr(6'h3E, 4'h1);
    pulse(6'h04);
    tick(2);
    chk({3'h0, intr_request_r}, 4'h1);
    chk(intr_vector_r, VEC_TIMER);
    pulse(6'h08);
    tick(2);
    chk({3'h0, intr_request_r}, 4'h0);
    rd(6'h3E, 4'h1);
    pulse(6'h04);
    tick(2);
    wr(6'h2F, 4'h5);
    tick(2);
    chk({3'h0, intr_request_r}, 4'h0);
    // Restart bit and stop instruction clear the timer flag.
    pulse(6'h10);
    rd(6'h3E, 4'h0);
    wr(6'h3E, 4'h1);
    pulse(6'h20);
    rd(6'h3E, 4'h0);
    // A reset in mid-run drops an offered request and all settings.
    wr(6'h3D, 4'h1);
    tick(2);
    chk({3'h0, intr_request_r}, 4'h1);
    chk(intr_vector_r, VEC_SERIAL);
    do_reset();
    chk({3'h0, intr_request_r}, 4'h0);
    rd(6'h3D, 4'h0);
    rd(6'h2F, 4'h0);
    stop_test();
  end
endmodule : test_interrupt_flag_control

//--- verilog/interrupt_flag_control.sv
`timescale 1ns/1ps

// How it works
// R1: Flag sets on request, clears on acceptance.
// R2: Each source has its own enable bit.
// R3: Enable instruction sets global accept flag.
// R4: Global accept flag is never readable.
// R5: Disable instruction clears global accept flag.
// R6: Reset clears global accept flag.
// R7: Pin flag sets on selected pin edge.
// R8: Select 00 rising, 01 falling, else both.
// R9: Timer flag sets on count match.
// R10: Serial flag sets on transfer end.
// R11: Pin status is live; pin flag holds.
// R12: Writes to pin status do nothing.
// R13: Software write 0 cancels, 1 raises.
// R14: Pending read shows raised or held request.
// R15: Timer restart bit clears timer flag.
// R16: Stop instruction clears timer flag.
// R17: Priority pin, timer, serial; vectors 3,2,1.
// R18: Accept needs global, enable and pending.
// R19: Unused upper bits read zero, ignore writes.
module interrupt_flag_control (
  // Clock and reset.
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  // Register file access from the core.
  input  wire logic                        reg_wr_en,
  input  wire logic                        reg_rd_en,
  input  wire logic [intr_flag_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [intr_flag_pkg::DATA_W-1:0] reg_wr_data,
  output logic      [intr_flag_pkg::DATA_W-1:0] reg_rd_data_r,
  // Interrupt sources.
  input  wire logic                        int_pin,
  input  wire logic                        timer_match,
  input  wire logic                        serial_done,
  // Instruction strobes from the core sequencer.
  input  wire logic                        accept_on_instr,
  input  wire logic                        accept_off_instr,
  input  wire logic                        timer_restart_bit,
  input  wire logic                        stop_instr,
  input  wire logic                        intr_ack,
  // Request toward the core sequencer.
  output logic                             intr_request_r,
  output logic      [intr_flag_pkg::VEC_W-1:0]  intr_vector_r
);

  import intr_flag_pkg::*;

  // Stored state.
  logic [1:0]         edge_sel_r;          // Pin edge select field.
  logic [NUM_SRC-1:0] enable_r;            // Per-source enable flags.
  logic [NUM_SRC-1:0] pend_r;              // Per-source pending flags.
  logic               global_accept_flag_r; // Global accept, hidden.

  // Next values.
  logic [1:0]         edge_sel_nxt;        // Edge select next value.
  logic [NUM_SRC-1:0] enable_nxt;          // Enable flags next value.
  logic [NUM_SRC-1:0] pend_nxt;            // Pending flags next value.
  logic               accept_nxt;          // Global accept next value.
  logic               request_nxt;         // Request line next value.
  logic [VEC_W-1:0]   vector_nxt;          // Vector next value.
  logic [DATA_W-1:0]  rd_data_nxt;         // Read data next value.
  logic [DATA_W-1:0]  rd_mux;              // Selected register image.

  // Named views of the fields, for readability.
  wire pin_edge_sel_lo   = edge_sel_r[EDGE_SEL_LO_BIT];
  wire pin_edge_sel_hi   = edge_sel_r[EDGE_SEL_HI_BIT];
  wire pin_req_enable    = enable_r[SRC_PIN];
  wire timer_req_enable  = enable_r[SRC_TIMER];
  wire serial_req_enable = enable_r[SRC_SERIAL];
  wire timer_req_pending  = pend_r[SRC_TIMER];
  wire serial_req_pending = pend_r[SRC_SERIAL];
  wire pin_req_pending    = pend_r[SRC_PIN];

  // Pin conditioning results.
  wire pin_level;                          // Synchronised pin level.
  wire pin_edge;                           // Selected edge, one cycle.

  // Write decode.
  wire wr_edge_sel = reg_wr_en && (reg_addr == ADDR_EDGE_SEL);
  wire wr_enable   = reg_wr_en && (reg_addr == ADDR_ENABLE);
  wire wr_bit      = reg_wr_data[FLAG_BIT];
  wire [NUM_SRC-1:0] wr_pend;              // Write hits a pending flag.

  // Event gathering per source.
  wire [NUM_SRC-1:0] src_event;            // Hardware request pulses.
  wire [NUM_SRC-1:0] src_side_clr;         // Extra clears per source.
  wire [NUM_SRC-1:0] ack_src;              // Acceptance of each source.
  wire [NUM_SRC-1:0] armed;                // Pending, enabled, accepted.

  // An acknowledge only counts while a request is actually shown, so a
  // stray strobe from the core cannot clear a flag that was never offered.
  wire ack_fire = intr_ack && intr_request_r;

  // Pin synchroniser and edge selection.
  pin_edge_detect u_pin_edge (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_raw   (int_pin),
    .edge_sel  ({pin_edge_sel_hi, pin_edge_sel_lo}),
    .pin_level (pin_level),
    .pin_edge  (pin_edge)
  );

  // Hardware request sources, one per flag.
  assign src_event[SRC_PIN]    = pin_edge;      // see R7
  assign src_event[SRC_TIMER]  = timer_match;   // see R9
  assign src_event[SRC_SERIAL] = serial_done;   // see R10

  // Only the timer flag has clears beyond acceptance and software.
  assign src_side_clr[SRC_PIN]    = 1'h0;
  assign src_side_clr[SRC_TIMER]  = timer_restart_bit | // see R15
                                    stop_instr;         // see R16
  assign src_side_clr[SRC_SERIAL] = 1'h0;

  // A request needs all three permissions at once.
  assign armed = pend_r & enable_r &                    // see R2
                 {NUM_SRC{global_accept_flag_r}};       // see R18

  // One pending flag per source. The set terms beat every clear term, so
  // an event landing in the same cycle as a cancel or an acceptance is
  // kept; the cost is that software cannot cancel a request that fires
  // in exactly the cycle of its write.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_pend
      wire set_term;
      wire clr_term;

      assign wr_pend[gi] = reg_wr_en && (reg_addr == PEND_ADDR[gi]);
      assign ack_src[gi] = ack_fire && (intr_vector_r == SRC_VEC[gi]);

      // Source event or a written 1 raises the flag.
      assign set_term = src_event[gi] |                 // see R1
                        (wr_pend[gi] & wr_bit);         // see R13
      // Acceptance, a written 0 or a side clear drops it.
      assign clr_term = ack_src[gi] |                   // see R1
                        (wr_pend[gi] & ~wr_bit) |       // see R13
                        src_side_clr[gi];

      // Hold the flag until something clears it; the pin flag stays up
      // after the pin returns, whatever the live level does.
      assign pend_nxt[gi] = set_term ? 1'h1 :
                            clr_term ? 1'h0 :
                            pend_r[gi];                 // see R11

      // Flag storage.
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          pend_r[gi] <= RST_PEND;
        end else begin
          pend_r[gi] <= pend_nxt[gi];
        end
      end
    end
  endgenerate

  // Only the defined low bits are stored; upper written bits are dropped.
  assign edge_sel_nxt = wr_edge_sel ? reg_wr_data[1:0] :   // see R19
                        edge_sel_r;
  assign enable_nxt   = wr_enable ? reg_wr_data[NUM_SRC-1:0] : // see R19
                        enable_r;

  // Global accept flag. Disable wins over enable when both arrive, and
  // acceptance drops the flag so the single-level stack is not overrun;
  // software enables again before returning.
  always_comb begin
    accept_nxt = global_accept_flag_r;
    if (accept_off_instr) begin
      accept_nxt = 1'h0;                               // see R5
    end else if (ack_fire) begin
      accept_nxt = 1'h0;
    end else if (accept_on_instr) begin
      accept_nxt = 1'h1;                               // see R3
    end
  end

  // Fixed priority: pin, then timer, then serial. The request is dropped
  // in the acceptance cycle because the flags only clear one edge later.
  always_comb begin
    request_nxt = (|armed) && !ack_fire;               // see R18
    vector_nxt  = VEC_NONE;
    if (armed[SRC_PIN]) begin
      vector_nxt = VEC_PIN;                            // see R17
    end else if (armed[SRC_TIMER]) begin
      vector_nxt = VEC_TIMER;                          // see R17
    end else if (armed[SRC_SERIAL]) begin
      vector_nxt = VEC_SERIAL;                         // see R17
    end
    if (!request_nxt) begin
      vector_nxt = VEC_NONE;
    end
  end

  // Read selection. The global accept flag has no location at all, and
  // the pin status has no write decode, so writes to it vanish.
  always_comb begin
    case (reg_addr)
      ADDR_PIN_STATUS: rd_mux = {3'h0, pin_level};         // see R11
      ADDR_EDGE_SEL:   rd_mux = {2'h0, edge_sel_r};        // see R19
      ADDR_ENABLE:     rd_mux = {1'h0, serial_req_enable,
                                 timer_req_enable, pin_req_enable};
      ADDR_SERIAL_REQ: rd_mux = {3'h0, serial_req_pending}; // see R14
      ADDR_TIMER_REQ:  rd_mux = {3'h0, timer_req_pending};  // see R14
      ADDR_PIN_REQ:    rd_mux = {3'h0, pin_req_pending};    // see R14
      default:         rd_mux = 4'h0;                       // see R4
    endcase
  end

  // Read data is captured on the strobe and held until the next one.
  assign rd_data_nxt = reg_rd_en ? rd_mux : reg_rd_data_r; // see R12

  // Control register storage.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_sel_r <= RST_EDGE_SEL;
      enable_r   <= RST_ENABLE;
    end else begin
      edge_sel_r <= edge_sel_nxt;
      enable_r   <= enable_nxt;
    end
  end

  // Global accept storage; reset leaves every interrupt blocked.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_accept_flag_r <= RST_ACCEPT;              // see R6
    end else begin
      global_accept_flag_r <= accept_nxt;
    end
  end

  // Output registers toward the core.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      intr_request_r <= 1'h0;
      intr_vector_r  <= VEC_NONE;
      reg_rd_data_r  <= RST_RD_DATA;
    end else begin
      intr_request_r <= request_nxt;
      intr_vector_r  <= vector_nxt;
      reg_rd_data_r  <= rd_data_nxt;
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // The enable instruction raises the accept flag on the next edge.
  a_ei_sets_accept: assert property ( // see R3
    accept_on_instr && !accept_off_instr && !ack_fire
      |=> global_accept_flag_r)
    else $error("enable instruction did not set accept flag");

  // The disable instruction clears the accept flag, and one edge after that no request is shown.
  a_di_blocks_all: assert property ( // see R5
    accept_off_instr && !accept_on_instr
      |=> !global_accept_flag_r ##1 !intr_request_r)
    else $error("disable instruction did not block requests");

  // Timer match raises the timer flag on the next edge.
  a_timer_match_sets: assert property ( // see R9
    timer_match |=> timer_req_pending)
    else $error("timer match lost");

  // Serial transfer end raises the serial flag on the next edge.
  a_serial_end_sets: assert property ( // see R10
    serial_done |=> serial_req_pending)
    else $error("serial transfer end lost");

  // A selected pin edge raises the pin flag on the next edge.
  a_pin_edge_sets: assert property ( // see R7
    pin_edge |=> pin_req_pending)
    else $error("pin edge lost");

  // A shown request always had all three permissions one edge before.
  a_request_gated: assert property ( // see R18
    intr_request_r |-> $past(global_accept_flag_r)
      && $past(|(pend_r & enable_r)))
    else $error("request raised without permission");

  // An armed pin request always wins the vector.
  a_pin_first: assert property ( // see R17
    intr_request_r && $past(armed[SRC_PIN]) |-> intr_vector_r == VEC_PIN)
    else $error("pin request lost priority");

  // Restart or stop clears the timer flag unless a set arrives with it.
  a_restart_clears: assert property ( // see R15
    (timer_restart_bit || stop_instr) && !timer_match
      && !(wr_pend[SRC_TIMER] && wr_bit) |=> !timer_req_pending)
    else $error("timer flag survived restart or stop");

  // Accepting the serial interrupt clears its flag.
  a_ack_clears_flag: assert property ( // see R1
    ack_fire && intr_vector_r == VEC_SERIAL && !serial_done
      && !(wr_pend[SRC_SERIAL] && wr_bit) |=> !serial_req_pending)
    else $error("accepted flag not cleared");

  // Bit 3 of every location reads as zero.
  a_upper_bit_zero: assert property ( // see R19
    reg_rd_en |=> reg_rd_data_r[DATA_W-1] == 1'h0)
    else $error("unused upper bit read as one");

endmodule : interrupt_flag_control

//--- verilog/intr_flag_pkg.sv
package intr_flag_pkg;

  // Register file geometry: six address bits, four data bits.
  localparam int ADDR_W  = 6;
  localparam int DATA_W  = 4;
  localparam int NUM_SRC = 3;
  localparam int VEC_W   = 4;

  // Register file locations served by this block.
  localparam logic [ADDR_W-1:0] ADDR_PIN_STATUS = 6'h0F;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL   = 6'h1F;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE     = 6'h2F;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_REQ = 6'h3D;
  localparam logic [ADDR_W-1:0] ADDR_TIMER_REQ  = 6'h3E;
  localparam logic [ADDR_W-1:0] ADDR_PIN_REQ    = 6'h3F;

  // Source indices, also the bit positions inside the enable register.
  localparam int SRC_PIN    = 0;
  localparam int SRC_TIMER  = 1;
  localparam int SRC_SERIAL = 2;

  // Field positions.
  localparam int FLAG_BIT        = 0;
  localparam int EDGE_SEL_LO_BIT = 0;
  localparam int EDGE_SEL_HI_BIT = 1;

  // Edge select codes; every other code means both edges.
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  // Vector addresses handed to the core sequencer.
  localparam logic [VEC_W-1:0] VEC_NONE   = 4'h0;
  localparam logic [VEC_W-1:0] VEC_PIN    = 4'h3;
  localparam logic [VEC_W-1:0] VEC_TIMER  = 4'h2;
  localparam logic [VEC_W-1:0] VEC_SERIAL = 4'h1;

  // Per-source tables, indexed by the source index.
  localparam logic [NUM_SRC-1:0][ADDR_W-1:0] PEND_ADDR =
    {ADDR_SERIAL_REQ, ADDR_TIMER_REQ, ADDR_PIN_REQ};
  localparam logic [NUM_SRC-1:0][VEC_W-1:0] SRC_VEC =
    {VEC_SERIAL, VEC_TIMER, VEC_PIN};

  // Reset values.
  localparam logic [1:0]         RST_EDGE_SEL = 2'h0;
  localparam logic [NUM_SRC-1:0] RST_ENABLE   = 3'h0;
  localparam logic               RST_PEND     = 1'h0;
  localparam logic               RST_ACCEPT   = 1'h0;
  localparam logic [DATA_W-1:0]  RST_RD_DATA  = 4'h0;
  localparam logic [1:0]         RST_SYNC     = 2'h0;

endpackage : intr_flag_pkg

//--- verilog/pin_edge_detect.sv
`timescale 1ns/1ps

module pin_edge_detect
  import intr_flag_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Raw pin and edge choice.
  input  wire logic       pin_raw,
  input  wire logic [1:0] edge_sel,
  // Synchronised level and one-cycle edge pulse.
  output logic            pin_level,
  output logic            pin_edge
);

  logic [1:0] sync_r;   // Two-stage synchroniser, bit 0 is the first stage.
  logic       prev_r;   // Previous synchronised level for edge detection.
  wire        rise;     // Low to high seen on the synchronised level.
  wire        fall;     // High to low seen on the synchronised level.

  // The pin is asynchronous, so only the second stage is ever looked at.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= RST_SYNC;
      prev_r <= 1'h0;
    end else begin
      sync_r <= {sync_r[0], pin_raw};
      prev_r <= sync_r[1];
    end
  end

  assign pin_level = sync_r[1];
  assign rise      = sync_r[1] & ~prev_r;
  assign fall      = ~sync_r[1] & prev_r;

  // Code 00 takes rising, 01 falling, anything else both edges.
  assign pin_edge = (edge_sel == EDGE_RISE) ? rise :   // see R8
                    (edge_sel == EDGE_FALL) ? fall :   // see R8
                    (rise | fall);                     // see R8

endmodule : pin_edge_detect
